//--- common/txctl_map.svh
// Offsets, field positions, reset values and timing counts of the transmit control block
`ifndef TXCTL_MAP_SVH
`define TXCTL_MAP_SVH

// ----------------------------------------
// Write offsets
// ----------------------------------------
`define W_TXDATA      4'h0
`define W_TXRX        4'h1
`define W_MODES       4'h2
`define W_TXCTL       4'h3
`define W_SYNC1       4'h4
`define W_SYNC2       4'h5
`define W_CODING      4'h6
`define W_MISC        4'h7
`define W_SELECT      4'h8
`define W_CMD         4'h9

// ----------------------------------------
// Read offsets
// ----------------------------------------
`define R_STATUS      4'h0
`define R_TXRX        4'h1
`define R_MODES       4'h2
`define R_TXCTL       4'h3
`define R_OPTS        4'h5
`define R_CODING      4'h6

// ----------------------------------------
// Field positions and encodings
// ----------------------------------------
`define TC_DTR        7
`define TC_LEN_HI     6
`define TC_LEN_LO     5
`define TC_BREAK      4
`define TC_EN         3
`define TC_POLY       2
`define TC_RTS        1
`define TC_CRC        0
`define LEN_5LESS     2'h0
`define LEN_7         2'h1
`define LEN_6         2'h2
`define LEN_8         2'h3
`define MM_STOP_HI    3
`define MM_STOP_LO    2
`define MM_SYNC_HI    5
`define MM_SYNC_LO    4
`define STOP_SYNC     2'h0
`define STOP_ONE      2'h1
`define SM_MONO       2'h0
`define SM_BI         2'h1
`define SM_SDLC       2'h2
`define TR_AUTO_EN    5
`define CC_PRESET     7
`define CC_ABORT      2
`define MC_REQ        2
`define MC_ECHO       3
`define MC_LOOP       4
`define OP_EXT        6
`define OP_FIFO       5
`define OP_REQT       4
`define OP_ARTS       2
`define SEL_OPT       0
`define CMD_CHRST     0

// ----------------------------------------
// Reset values, polynomials, timing
// ----------------------------------------
`define MODES_RST     8'h04
`define POLY_CRC16    16'ha001
`define POLY_LINK     16'h8408
`define PCLK_NS       40
`define REQ_DELAY_PCLK 4
`define REQ_DELAY_CYC 3'((`REQ_DELAY_PCLK * `PCLK_NS + `PCLK_NS - 1) / `PCLK_NS)

`endif

//--- common/txctl_pkg.sv
// Types shared by the transmit control block and its helpers
package txctl_pkg;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_DATA   = 5'h02,
    ST_CRC_LO = 5'h04,
    ST_CRC_HI = 5'h08,
    ST_FILL   = 5'h10
  } tx_state_t;

  typedef struct packed {
    logic [15:0] shift;
    logic [4:0]  cnt;
    logic        busy;
    logic        done;
  } shift_state_t;

  typedef struct packed {
    logic txc_s1, txc_s2, txc_d, rxd_s1, rxd_s2;
    logic [7:0] txrx, modes, txctl, sync1, sync2, opts, coding, misc, select;
    logic [7:0] entry, inner;
    logic entry_full, inner_full;
    tx_state_t st;
    logic load, crc_inc, crc_preset, closing, rts_hold, rts_arm;
    logic [15:0] value;
    logic [4:0]  nbits;
    logic [2:0]  req_cnt;
    logic req_act, txd, rts_n, dtr_req_n, tx_req;
    logic [7:0] rdata;
  } ctrl_state_t;
endpackage

//--- common/tx_path_if.sv
// Path between the transmit controller, its shift register and its CRC generator
`timescale 1ns/1ns
interface tx_path_if;
  logic        tick;
  logic        load;
  logic [15:0] value;
  logic [4:0]  nbits;
  logic        busy;
  logic        done;
  logic        bit_out;
  logic        crc_preset;
  logic        preset_ones;
  logic        poly_sel;
  logic        crc_upd;
  logic [15:0] crc;
  modport ctrl (output tick, load, value, nbits, crc_preset, preset_ones, poly_sel, crc_upd,
                input busy, done, bit_out, crc);
  modport shifter (input tick, load, value, nbits, output busy, done, bit_out);
  modport crc_gen (input crc_preset, preset_ones, poly_sel, crc_upd, bit_out, output crc);
endinterface

//--- design/tx_shifter.sv
// Transmit shift register, one bit per transmit clock tick, LSB first
`timescale 1ns/1ns
module tx_shifter (
  // Clock and reset
  input wire logic   core_clk,
  input wire logic   rst,
  // Controller side
  tx_path_if.shifter path
);
  txctl_pkg::shift_state_t r;
  txctl_pkg::shift_state_t next_r;

  // Load wins over a tick; the controller only loads while idle
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (path.load) begin
      next_r.shift = path.value;
      next_r.cnt = path.nbits;
      next_r.busy = 1'b1;
    end else if (path.tick && r.busy) begin
      next_r.shift = {1'b1, r.shift[15:1]};
      next_r.cnt = r.cnt - 5'h01;
      if (r.cnt == 5'h01) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Idle line marks
  assign path.busy = r.busy;
  assign path.done = r.done;
  assign path.bit_out = r.busy ? r.shift[0] : 1'b1;
endmodule

//--- design/tx_crc.sv
// Bit-serial transmit CRC generator, reflected form
`timescale 1ns/1ns
`include "txctl_map.svh"
module tx_crc (
  // Clock and reset
  input wire logic   core_clk,
  input wire logic   rst,
  // Controller side
  tx_path_if.crc_gen path
);
  logic [15:0] r;
  logic [15:0] next_r;
  logic [15:0] poly;
  logic        fb;

  // Preset takes priority over an update in the same cycle
  always_comb begin
    poly = path.poly_sel ? `POLY_CRC16 : `POLY_LINK;
    fb = r[0] ^ path.bit_out;
    next_r = r;
    if (path.crc_preset) begin
      next_r = path.preset_ones ? 16'hffff : 16'h0000;
    end else if (path.crc_upd) begin
      next_r = {1'b0, r[15:1]} ^ (fb ? poly : 16'h0000);
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= 16'h0000;
    end else begin
      r <= next_r;
    end
  end

  assign path.crc = r;
endmodule

//--- design/serial_tx_control_regs.sv
// Transmit control and option registers with the transmit line sequencer
// ----------------------------------------
// Behaviour
// RULE1 - In modem mode terminal-ready pin is low when its bit is one.
// RULE2 - Two-bit length field picks five-or-less, seven, six or eight bits.
// RULE3 - Five-or-less: ones over three zeros mark one to five data bits.
// RULE4 - Unused high bits are ignored at six or seven bits.
// RULE5 - Break drives zeros from the next transmit clock, even when disabled.
// RULE6 - Monosync loop mode clears break when receiver reaches sync.
// RULE7 - Transmitter disabled sends ones, except echo or loop; the code excepts echo only, loop mode still sends ones.
// RULE8 - Disable mid-character finishes it; CRC becomes sync or flag.
// RULE9 - Channel or hardware reset clears ready, break, enable, request bits.
// RULE10 - One bit picks CRC-16 or link polynomial; bit-oriented uses link.
// RULE11 - CRC presets to zeros or ones from a coding register bit.
// RULE12 - Request-to-send pin low when bit is one; follows bit in sync.
// RULE13 - Async auto enable holds request low until last stop bit leaves.
// RULE14 - Bit-oriented auto release at closing flag end on rising clock.
// RULE15 - CRC covers characters loaded with CRC enable; append on underrun too.
// RULE16 - First sync register: mono sync, first sync byte, station address.
// RULE17 - Station address is never inserted into frames automatically.
// RULE18 - Second sync register: receive sync, last bisync byte, flag.
// RULE19 - Option register shares the second sync address; survives channel reset.
// RULE20 - Host writes zero to option bit seven.
// RULE21 - Extended read returns five written registers at five read addresses.
// RULE22 - FIFO level bit picks fully empty or entry empty for requests.
// RULE23 - Request timing bit picks fast or four-clock pin deactivation.
// RULE24 - Character length is sampled when a character enters the shifter.
// ----------------------------------------
`timescale 1ns/1ns
`include "txctl_map.svh"
module serial_tx_control_regs (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Serial link pins
  input  wire logic       txc,
  input  wire logic       rxd,
  output logic            txd,
  output logic            rts_n,
  output logic            dtr_req_n,
  // Receiver status and transfer request
  input  wire logic       rx_char_sync,
  output logic            tx_req
);
  txctl_pkg::ctrl_state_t r;
  txctl_pkg::ctrl_state_t next_r;
  tx_path_if path ();

  logic [20:0] fmt;
  logic        tick;
  logic        rise;
  logic        sync_m;
  logic        sdlc;
  logic        tx_en;
  logic        can_go;
  logic        req_cond;
  logic        fifo_empty;
  logic [15:0] fill_value;
  logic [4:0]  fill_bits;

  // ----------------------------------------
  // Character formatting
  // ----------------------------------------
  // Returns {bit count, line value}; start and stop bits added in async mode
  function automatic logic [20:0] char_format(input logic [7:0] d, input logic [1:0] len,
                                              input logic async_m, input logic two_stop);
    logic [3:0]  n;
    logic [7:0]  mask;
    logic [15:0] v;
    logic [4:0]  total;
    begin
      n = 4'h8;
      unique case (len)
        `LEN_8: n = 4'h8;
        `LEN_7: n = 4'h7;
        `LEN_6: n = 4'h6;
        `LEN_5LESS: begin
          if (d[7:1] == 7'h78) n = 4'h1; // RULE3
          else if (d[7:2] == 6'h38) n = 4'h2; // RULE3
          else if (d[7:3] == 5'h18) n = 4'h3; // RULE3
          else if (d[7:4] == 4'h8) n = 4'h4; // RULE3
          else n = 4'h5; // RULE3
        end
      endcase
      mask = ~(8'hff << n);
      // Bits above the character read as ones so stop bits come for free
      v = {8'hff, (d & mask) | ~mask}; // RULE4
      total = {1'b0, n};
      if (async_m) begin
        v = {v[14:0], 1'b0};
        total = total + (two_stop ? 5'h3 : 5'h2);
      end
      char_format = {total, v};
    end
  endfunction

  // ----------------------------------------
  // Decoded conditions
  // ----------------------------------------
  // Edges of the synchronised transmit clock
  assign tick = r.txc_d & ~r.txc_s2;
  assign rise = ~r.txc_d & r.txc_s2;
  assign sync_m = r.modes[`MM_STOP_HI:`MM_STOP_LO] == `STOP_SYNC;
  assign sdlc = sync_m && (r.modes[`MM_SYNC_HI:`MM_SYNC_LO] == `SM_SDLC);
  assign tx_en = r.txctl[`TC_EN];
  assign can_go = ~path.busy & ~r.load;
  assign fifo_empty = ~r.entry_full & ~r.inner_full;
  // Length sampled at load time only
  assign fmt = char_format(r.inner, r.txctl[`TC_LEN_HI:`TC_LEN_LO], ~sync_m,
                           r.modes[`MM_STOP_HI:`MM_STOP_LO] != `STOP_ONE); // RULE2 RULE24

  // Time fill: flag, sixteen-bit sync, or single sync character
  always_comb begin
    if (sdlc) begin
      fill_value = {8'hff, r.sync2}; // RULE18
      fill_bits = 5'h08;
    end else if (r.modes[`MM_SYNC_HI:`MM_SYNC_LO] == `SM_BI) begin
      fill_value = {r.sync2, r.sync1}; // RULE16 RULE18
      fill_bits = 5'h10;
    end else begin
      fill_value = {8'hff, r.sync1}; // RULE16
      fill_bits = 5'h08;
    end
  end

  // Request condition follows the chosen FIFO level
  assign req_cond = tx_en & (r.opts[`OP_FIFO] ? fifo_empty : ~r.entry_full); // RULE22

  // ----------------------------------------
  // Path to shifter and CRC generator
  // ----------------------------------------
  assign path.tick = tick;
  assign path.load = r.load;
  assign path.value = r.value;
  assign path.nbits = r.nbits;
  assign path.crc_preset = r.crc_preset;
  assign path.preset_ones = r.coding[`CC_PRESET]; // RULE11
  // Bit-oriented framing always uses the link polynomial
  assign path.poly_sel = r.txctl[`TC_POLY] & ~sdlc; // RULE10
  assign path.crc_upd = tick & path.busy & r.crc_inc; // RULE15

  tx_shifter u_shifter (
    .core_clk (core_clk),
    .rst      (rst),
    .path     (path.shifter)
  );

  tx_crc u_crc (
    .core_clk (core_clk),
    .rst      (rst),
    .path     (path.crc_gen)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.txc_s1 = txc;
    next_r.txc_s2 = r.txc_s1;
    next_r.txc_d = r.txc_s2;
    next_r.rxd_s1 = rxd;
    next_r.rxd_s2 = r.rxd_s1;
    next_r.load = 1'b0;
    next_r.crc_preset = 1'b0;
    next_r.rdata = 8'h00;

    // Buffer entry drains into the inner slot first; a write below refills it
    if (r.entry_full && !r.inner_full) begin
      next_r.inner = r.entry;
      next_r.inner_full = 1'b1;
      next_r.entry_full = 1'b0;
    end

    // Character sequencer, only while the shifter is idle
    if (can_go) begin
      unique case (r.st)
        txctl_pkg::ST_IDLE, txctl_pkg::ST_DATA, txctl_pkg::ST_FILL: begin
          if (tx_en && r.inner_full) begin
            // Frame bytes, address included, come only from the host
            next_r.load = 1'b1; // RULE17
            next_r.value = fmt[15:0];
            next_r.nbits = fmt[20:16];
            next_r.crc_inc = r.txctl[`TC_CRC]; // RULE15
            next_r.inner_full = 1'b0;
            next_r.closing = 1'b0;
            next_r.st = txctl_pkg::ST_DATA;
          end else if (tx_en && sync_m && r.st == txctl_pkg::ST_DATA && r.txctl[`TC_CRC]) begin
            // Underrun with CRC enabled appends the CRC
            next_r.load = 1'b1; // RULE15
            next_r.value = {8'hff, path.crc[7:0]};
            next_r.nbits = 5'h08;
            next_r.crc_inc = 1'b0;
            next_r.st = txctl_pkg::ST_CRC_LO;
          end else if (tx_en && sync_m) begin
            next_r.load = 1'b1;
            next_r.value = fill_value;
            next_r.nbits = fill_bits;
            next_r.crc_inc = 1'b0;
            next_r.crc_preset = 1'b1; // RULE11
            next_r.closing = sdlc && r.st == txctl_pkg::ST_DATA;
            next_r.st = txctl_pkg::ST_FILL;
          end else begin
            // Disabled, or async with nothing queued: nothing new is loaded so the idle shifter marks
            next_r.crc_inc = 1'b0; // RULE7
            next_r.crc_preset = 1'b1;
            next_r.st = txctl_pkg::ST_IDLE;
          end
        end
        txctl_pkg::ST_CRC_LO: begin
          next_r.load = 1'b1;
          if (tx_en) begin
            next_r.value = {8'hff, path.crc[15:8]};
            next_r.nbits = 5'h08;
            next_r.st = txctl_pkg::ST_CRC_HI;
          end else begin
            // Disabled during CRC: a fill replaces the remaining CRC byte
            next_r.value = fill_value; // RULE8
            next_r.nbits = fill_bits;
            next_r.crc_preset = 1'b1;
            next_r.closing = sdlc;
            next_r.st = txctl_pkg::ST_FILL;
          end
        end
        txctl_pkg::ST_CRC_HI: begin
          next_r.load = 1'b1;
          next_r.value = fill_value; // RULE8
          next_r.nbits = fill_bits;
          next_r.crc_preset = 1'b1;
          next_r.closing = sdlc;
          next_r.st = txctl_pkg::ST_FILL;
        end
      endcase
    end

    // Register writes
    if (wr) begin
      case (addr)
        `W_TXDATA: begin
          next_r.entry = wdata;
          next_r.entry_full = 1'b1;
        end
        `W_TXRX: next_r.txrx = wdata;
        `W_MODES: next_r.modes = wdata;
        `W_TXCTL: next_r.txctl = wdata;
        `W_SYNC1: next_r.sync1 = wdata; // RULE16
        `W_SYNC2: begin
          // Same offset, steered by the selection bit
          if (r.select[`SEL_OPT]) next_r.opts = {1'b0, wdata[6:0]}; // RULE19 RULE20
          else next_r.sync2 = wdata; // RULE18
        end
        `W_CODING: next_r.coding = wdata;
        `W_MISC: next_r.misc = wdata;
        `W_SELECT: next_r.select = wdata;
        `W_CMD: begin
          // Channel reset leaves the option register untouched
          if (wdata[`CMD_CHRST]) begin
            next_r.txctl[`TC_DTR] = 1'b0; // RULE9
            next_r.txctl[`TC_BREAK] = 1'b0; // RULE9
            next_r.txctl[`TC_EN] = 1'b0; // RULE9
            next_r.txctl[`TC_RTS] = 1'b0; // RULE9
          end
        end
        default: begin
        end
      endcase
    end

    // Receiver sync ends break in monosync loop operation
    if (r.txctl[`TC_BREAK] && r.misc[`MC_LOOP] && sync_m && rx_char_sync
        && r.modes[`MM_SYNC_HI:`MM_SYNC_LO] == `SM_MONO) begin
      next_r.txctl[`TC_BREAK] = 1'b0; // RULE6
    end

    // Line driven once per transmit clock; break overrides data in flight
    if (tick) begin
      if (r.txctl[`TC_BREAK]) next_r.txd = 1'b0; // RULE5
      else if (r.misc[`MC_ECHO]) next_r.txd = r.rxd_s2;
      else next_r.txd = path.bit_out; // RULE7
    end

    // Request-to-send hold and automatic release
    if (next_r.txctl[`TC_RTS]) begin
      next_r.rts_hold = 1'b1;
      next_r.rts_arm = 1'b0;
    end else if (r.rts_hold) begin
      if (!sync_m && r.txrx[`TR_AUTO_EN]) begin
        // Released one tick after the last stop bit went out
        if (tick && can_go && fifo_empty && !path.busy) next_r.rts_hold = 1'b0; // RULE13
      end else if (sdlc && !r.coding[`CC_ABORT] && r.opts[`OP_ARTS]) begin
        if (path.done && r.closing) next_r.rts_arm = 1'b1; // RULE14
        if (r.rts_arm && rise) next_r.rts_hold = 1'b0; // RULE14
      end else begin
        next_r.rts_hold = 1'b0; // RULE12
      end
    end
    next_r.rts_n = ~(next_r.txctl[`TC_RTS] | next_r.rts_hold); // RULE12

    // Request pin: a data write ends it at once or after four clocks
    if (wr && addr == `W_TXDATA) begin
      if (r.opts[`OP_REQT]) next_r.req_act = 1'b0; // RULE23
      else next_r.req_cnt = `REQ_DELAY_CYC; // RULE23
    end else if (r.req_cnt != 3'h0) begin
      next_r.req_cnt = r.req_cnt - 3'h1;
      if (r.req_cnt == 3'h1) next_r.req_act = 1'b0; // RULE23
    end else if (req_cond) begin
      next_r.req_act = 1'b1; // RULE22
    end
    next_r.tx_req = req_cond; // RULE22
    next_r.dtr_req_n = r.misc[`MC_REQ] ? ~next_r.req_act : ~next_r.txctl[`TC_DTR]; // RULE1

    // Read data stand for the one cycle after the strobe
    if (rd) begin
      case (addr)
        `R_STATUS: next_r.rdata = {3'h0, r.rts_hold, r.st == txctl_pkg::ST_IDLE && !path.busy,
                                   path.busy, fifo_empty, ~r.entry_full};
        `R_TXRX: next_r.rdata = r.opts[`OP_EXT] ? r.txrx : 8'h00; // RULE21
        `R_MODES: next_r.rdata = r.opts[`OP_EXT] ? r.modes : 8'h00; // RULE21
        `R_TXCTL: next_r.rdata = r.opts[`OP_EXT] ? r.txctl : 8'h00; // RULE21
        `R_OPTS: next_r.rdata = r.opts[`OP_EXT] ? r.opts : 8'h00; // RULE21
        `R_CODING: next_r.rdata = r.opts[`OP_EXT] ? r.coding : 8'h00; // RULE21
        default: next_r.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Hardware reset clears everything but modes and state, options included, and parks pins high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= '0; // RULE9
      r.modes <= `MODES_RST;
      r.st <= txctl_pkg::ST_IDLE;
      r.txd <= 1'b1;
      r.rts_n <= 1'b1;
      r.dtr_req_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign rdata = r.rdata;
  assign txd = r.txd;
  assign rts_n = r.rts_n;
  assign dtr_req_n = r.dtr_req_n;
  assign tx_req = r.tx_req;
endmodule

//--- tb/serial_tx_control_regs_asserts.sv
// Assertion checker for the transmit control register block
`timescale 1ns/1ns
`include "txctl_map.svh"
module serial_tx_control_regs_asserts (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // Serial link pins
  input wire logic       txc,
  input wire logic       rxd,
  input wire logic       txd,
  input wire logic       rts_n,
  input wire logic       dtr_req_n,
  // Receiver status and request
  input wire logic       rx_char_sync,
  input wire logic       tx_req
);
  logic [7:0] txctl_sh;
  logic [7:0] modes_sh;
  logic [7:0] misc_sh;
  logic [7:0] opts_sh;
  logic       sel_sh;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Shadow registers
  // ----------------------------------------
  // Mirrors host writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txctl_sh <= 8'h00;
      modes_sh <= 8'h04;
      misc_sh  <= 8'h00;
      opts_sh  <= 8'h00;
      sel_sh   <= 1'b0;
    end else if (wr) begin
      if (addr == `W_TXCTL) txctl_sh <= wdata;
      if (addr == `W_MODES) modes_sh <= wdata;
      if (addr == `W_MISC) misc_sh <= wdata;
      if (addr == `W_SELECT) sel_sh <= wdata[`SEL_OPT];
      if (addr == `W_SYNC2 && sel_sh) opts_sh <= {1'b0, wdata[6:0]}; // Top bit never kept
      if (addr == `W_CMD && wdata[`CMD_CHRST]) txctl_sh <= txctl_sh & 8'h65; // Options survive
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_dtr_level;
    !misc_sh[`MC_REQ] && !$past(wr) |-> dtr_req_n == !txctl_sh[`TC_DTR];
  endproperty
  a_dtr_level: assert property (p_dtr_level) else $error("terminal-ready pin level wrong");
  property p_rts_follow;
    modes_sh[3:2] == `STOP_SYNC && modes_sh[5:4] != `SM_SDLC && !$past(wr) |-> rts_n == !txctl_sh[`TC_RTS];
  endproperty
  a_rts_follow: assert property (p_rts_follow) else $error("request pin not following bit");
  property p_chres;
    wr && addr == `W_CMD && wdata[`CMD_CHRST] |-> ##2 rts_n && (misc_sh[`MC_REQ] || dtr_req_n);
  endproperty
  a_chres: assert property (p_chres) else $error("modem pins not released by channel reset");
  property p_rd_idle;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_unmapped;
    rd && (addr == 4'h4 || addr > 4'h6) |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ext_off;
    rd && !opts_sh[`OP_EXT] && addr != `R_STATUS |=> rdata == 8'h00;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("readback without extended read");
  property p_opts_rd;
    rd && opts_sh[`OP_EXT] && addr == `R_OPTS |=> rdata == $past(opts_sh);
  endproperty
  a_opts_rd: assert property (p_opts_rd) else $error("option readback wrong");
  property p_txctl_rd;
    rd && opts_sh[`OP_EXT] && addr == `R_TXCTL |=> rdata == $past(txctl_sh);
  endproperty
  a_txctl_rd: assert property (p_txctl_rd) else $error("transmit control readback wrong");
  property p_txd_tick;
    $changed(txd) |-> $past(txc, 5) && !$past(txc, 2);
  endproperty
  a_txd_tick: assert property (p_txd_tick) else $error("line changed away from a clock fall");
  property p_break;
    txctl_sh[`TC_BREAK] && $past(txctl_sh[`TC_BREAK], 8) && $past(txc, 6) && !$past(txc, 4) |-> !txd;
  endproperty
  a_break: assert property (p_break) else $error("line not low during break");
endmodule

bind serial_tx_control_regs serial_tx_control_regs_asserts u_asserts (.core_clk(core_clk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .txc(txc), .rxd(rxd), .txd(txd),
  .rts_n(rts_n), .dtr_req_n(dtr_req_n), .rx_char_sync(rx_char_sync), .tx_req(tx_req));

//--- tb/link_station.sv
// Remote station model: clocks the line during a frame and samples it
`timescale 1ns/1ns
module link_station (
  // Frame control
  input  wire logic        go,
  output logic             done,
  output logic [11:0]      cap,
  // Line pins
  input  wire logic        txd,
  output logic             txc,
  output logic             rxd
);
  int k;

  // Clock rests high between frames
  initial begin
    txc  = 1'b1;
    rxd  = 1'b1;
    done = 1'b0;
    cap  = 12'h000;
  end

  // Twelve bit periods, line sampled on each rising edge
  always @(posedge go) begin
    #37;
    for (k = 0; k < 12; k++) begin
      #160 txc = 1'b0;
      rxd = ~rxd;
      #160 txc = 1'b1;
      rxd = ~rxd;
      cap[k] = txd;
    end
    done = ~done;
  end
endmodule

//--- tb/serial_tx_control_regs_tb.sv
// Self-checking bench for the transmit control register block
`timescale 1ns/1ns
`include "txctl_map.svh"
module serial_tx_control_regs_tb;
  logic        core_clk;
  logic        rst;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        txc;
  logic        rxd;
  logic        txd;
  logic        rts_n;
  logic        dtr_req_n;
  logic        rx_char_sync;
  logic        tx_req;
  logic        go;
  logic        fdone;
  logic [11:0] cap;
  int          error_cnt;
  int          n_checks;
  int          cyc;
  int          i;
  // Length, break and disable cases; frame bit 0 is the first bit on the line
  logic [7:0]  cfg [8] = '{8'h68, 8'h28, 8'h48, 8'h08, 8'h08, 8'h78, 8'h10, 8'h00};
  logic [7:0]  dat [8] = '{8'ha5, 8'h7f, 8'h3f, 8'hc5, 8'h16, 8'ha5, 8'h00, 8'h00};
  logic [11:0] frm [8] = '{12'hf4a, 12'hffe, 12'hffe, 12'hffa, 12'hfec, 12'h000, 12'h000, 12'hfff};

  serial_tx_control_regs u_dut (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .txc(txc), .rxd(rxd), .txd(txd), .rts_n(rts_n), .dtr_req_n(dtr_req_n),
    .rx_char_sync(rx_char_sync), .tx_req(tx_req));
  link_station u_station (.go(go), .done(fdone), .cap(cap), .txd(txd), .txc(txc), .rxd(rxd));

  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    @(posedge core_clk);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    chk(what, {4'h0, rdata}, {4'h0, exp});
    @(posedge core_clk);
  endtask
  // Pins as {txd, rts_n, dtr_req_n}, sampled mid-cycle
  task automatic chk_pins(input logic [2:0] exp);
    @(negedge core_clk);
    chk("pins", {9'h000, txd, rts_n, dtr_req_n}, {9'h000, exp});
    @(posedge core_clk);
  endtask
  task automatic frame;
    logic prev;
    prev = fdone;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    while (fdone === prev) @(posedge core_clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    rx_char_sync = 1'b0;
    go = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    chk_pins(3'b111);
    rd_chk(`R_TXCTL, 8'h00, "readback off");
    wr_reg(`W_SELECT, 8'h01);
    wr_reg(`W_SYNC2, 8'h44);
    wr_reg(`W_SELECT, 8'h00);
    wr_reg(`W_SYNC2, 8'h7e);
    rd_chk(`R_OPTS, 8'h44, "options");
    wr_reg(`W_TXCTL, 8'h8a);
    chk_pins(3'b100);
    chk("req", tx_req, 1'b1);
    rd_chk(`R_TXCTL, 8'h8a, "txctl");
    wr_reg(`W_CMD, 8'h01);
    rd_chk(`R_TXCTL, 8'h00, "txctl after reset");
    rd_chk(`R_OPTS, 8'h44, "options after reset");
    chk_pins(3'b111);
    rd_chk(4'hf, 8'h00, "unmapped");
    // Synchronous mode: request pin tracks its bit both ways
    wr_reg(`W_MODES, 8'h00);
    wr_reg(`W_TXCTL, 8'h02);
    chk_pins(3'b101);
    wr_reg(`W_TXCTL, 8'h00);
    chk_pins(3'b111);
    wr_reg(`W_MODES, 8'h04);
    // Each length setting changed just before its character is loaded
    for (i = 0; i < 8; i++) begin
      wr_reg(`W_TXCTL, cfg[i]);
      wr_reg(`W_TXDATA, dat[i]);
      repeat (4) @(posedge core_clk);
      frame();
      chk("frame", cap, frm[i]);
    end
    end_of_test();
  end
endmodule
